//--- inc/tsr_pkg.sv
// How it works
// - Raw object: 17 bits, regs 1-3[7]
// - Raw ambient: 15 bits, regs 3[6:0]-4
// - Filter one: 20 bits, eight times raw
// - Filter two: 20 bits, eight times raw
// - Ambient filter three: 16 bits, twice raw
// - Motion freezes filter two, 128 times raw
// - Presence magnitude, source selectable, sign separate
// - Motion magnitude between cycle-time spaced samples
// - Ambient shock magnitude, raw minus filtered
// - Latched status keeps every event between reads
// - Reading latched status clears it, releases pin
// - Bits 4-0 latch over-temp..timer events
// - Bits 7-5 latch signs at event time
// - Timer bit set after full timer period
// - Live status same layout, not read-cleared
// - Masked rising flag asserts pin until read
// - Pointer increments per byte, wraps after 63
// - Live timer bit toggles at double rate
package tsr_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [5:0] OFS_OBJ_HIGH = 6'h01;
  localparam logic [5:0] OFS_OBJ_MID = 6'h02;
  localparam logic [5:0] OFS_OBJ_LOW_AMB_HIGH = 6'h03;
  localparam logic [5:0] OFS_AMB_LOW = 6'h04;
  localparam logic [5:0] OFS_F1_HIGH = 6'h05;
  localparam logic [5:0] OFS_F1_MID = 6'h06;
  localparam logic [5:0] OFS_F1_LOW_F2_HIGH = 6'h07;
  localparam logic [5:0] OFS_F2_MID = 6'h08;
  localparam logic [5:0] OFS_F2_LOW = 6'h09;
  localparam logic [5:0] OFS_AF_HIGH = 6'h0a;
  localparam logic [5:0] OFS_AF_LOW = 6'h0b;
  localparam logic [5:0] OFS_FRZ_HIGH = 6'h0c;
  localparam logic [5:0] OFS_FRZ_MID = 6'h0d;
  localparam logic [5:0] OFS_FRZ_LOW = 6'h0e;
  localparam logic [5:0] OFS_PRESENCE = 6'h0f;
  localparam logic [5:0] OFS_MOTION = 6'h10;
  localparam logic [5:0] OFS_SHOCK = 6'h11;
  localparam logic [5:0] OFS_LATCHED = 6'h12;
  localparam logic [5:0] OFS_LIVE = 6'h13;
  localparam logic [5:0] ADDR_LAST = 6'h3f;
  // ****************************************
  // Field widths and scaling shifts
  // ****************************************
  localparam int OBJ_W = 17;
  localparam int AMB_W = 15;
  localparam int FILT_W = 20;
  localparam int AF_W = 16;
  localparam int FRZ_W = 24;
  localparam int FILT_SHIFT = 3;
  localparam int FRZ_SHIFT = 4;
  // ****************************************
  // Status bit positions and resets
  // ****************************************
  localparam int BIT_TIMER = 0;
  localparam int BIT_SHOCK = 1;
  localparam int BIT_MOTION = 2;
  localparam int BIT_PRESENCE = 3;
  localparam int BIT_OT = 4;
  localparam int BIT_SGN_SHOCK = 5;
  localparam int BIT_SGN_MOTION = 6;
  localparam int BIT_SGN_PRESENCE = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [1:0] TIMER_HALVES = 2'h2;
  typedef enum logic [1:0] {
    TSR_SRC_OBJ_F2, TSR_SRC_F1_F2, TSR_SRC_OBJ_FRZ, TSR_SRC_F1_FRZ
  } tsr_src_t;
endpackage

//--- core/tsr_status.sv
`timescale 1ns/100ps
`default_nettype none
module tsr_status (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Live conditions and events
  input wire logic [3:0] live_cond,
  input wire logic [2:0] live_sign,
  input wire logic timer_evt,
  input wire logic [4:0] mask,
  // Read side
  input wire logic rd_clear,
  output logic [7:0] latched,
  output logic int_pend
);
  import tsr_pkg::*;

  logic [3:0] cond_q;
  logic [4:0] evt;
  logic [7:0] next_latched;

  // Rising edges only: a standing condition is not an event
  assign evt = {live_cond & ~cond_q, timer_evt};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cond_q <= 4'h0;
    end else begin
      cond_q <= live_cond;
    end
  end

  always_comb begin
    next_latched = rd_clear ? STATUS_RESET : latched;
    next_latched[4:0] = next_latched[4:0] | evt;
    if (evt[BIT_SHOCK]) begin
      next_latched[BIT_SGN_SHOCK] = live_sign[0];
    end
    if (evt[BIT_MOTION]) begin
      next_latched[BIT_SGN_MOTION] = live_sign[1];
    end
    if (evt[BIT_PRESENCE]) begin
      next_latched[BIT_SGN_PRESENCE] = live_sign[2];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      latched <= STATUS_RESET;
    end else begin
      latched <= next_latched;
    end
  end

  // Set beats a same-cycle read so no event slips through
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      int_pend <= 1'b0;
    end else if (|(evt & mask)) begin
      int_pend <= 1'b1;
    end else if (rd_clear) begin
      int_pend <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_EVT_LATCHES: assert property (
    @(posedge mclk) disable iff (reset)
    |evt |=> ((latched[4:0] & $past(evt)) == $past(evt)))
    else $error("event not latched");
  AST_READ_CLEARS: assert property (
    @(posedge mclk) disable iff (reset)
    rd_clear && !(|evt) |=> latched == STATUS_RESET && !int_pend)
    else $error("read did not clear status");
  AST_INT_ON_MASKED: assert property (
    @(posedge mclk) disable iff (reset)
    |(evt & mask) |=> int_pend)
    else $error("masked event did not raise pin");
  AST_INT_HOLDS: assert property (
    @(posedge mclk) disable iff (reset)
    int_pend && !rd_clear |=> int_pend)
    else $error("pin dropped before read");
  AST_SIGN_CAPTURE: assert property (
    @(posedge mclk) disable iff (reset)
    evt[BIT_MOTION] |=> latched[BIT_SGN_MOTION] == $past(live_sign[1]))
    else $error("motion sign not captured");
  COV_INT_READ: cover property (
    @(posedge mclk) disable iff (reset) int_pend ##[1:20] rd_clear);
  COV_SET_CLEAR: cover property (
    @(posedge mclk) disable iff (reset) rd_clear && |evt);
endmodule
`default_nettype wire

//--- core/tsr_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tsr_regs (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // Sample inputs from the conversion and filter logic
  input wire logic SAMPLE_VALID,
  input wire logic [tsr_pkg::OBJ_W-1:0] OBJECT_RAW_SAMPLE,
  input wire logic [tsr_pkg::AMB_W-1:0] AMBIENT_RAW_SAMPLE,
  input wire logic [tsr_pkg::FILT_W-1:0] OBJECT_FILTER_ONE,
  input wire logic [tsr_pkg::FILT_W-1:0] OBJECT_FILTER_TWO,
  input wire logic [tsr_pkg::AF_W-1:0] AMBIENT_FILTER_THREE,
  // Controls and condition levels
  input wire logic [1:0] SRC_SELECT,
  input wire logic MOTION_TICK,
  input wire logic TIMER_HALF,
  input wire logic [4:0] INT_MASK,
  input wire logic OVER_TEMPERATURE_EVENT,
  input wire logic PRESENCE_COND,
  input wire logic MOTION_COND,
  input wire logic SHOCK_COND,
  // Register read port
  input wire logic RD_START,
  input wire logic [5:0] RD_ADDR,
  input wire logic RD_REQ,
  input wire logic RD_END,
  output logic [7:0] RD_DATA,
  output logic RD_ACK,
  // Interrupt pin
  output logic INT_N
);
  import tsr_pkg::*;

  // ****************************************
  // Live sample store
  // ****************************************
  logic [OBJ_W-1:0] obj;
  logic [AMB_W-1:0] amb;
  logic [FILT_W-1:0] f1;
  logic [FILT_W-1:0] f2;
  logic [AF_W-1:0] af;
  logic [FRZ_W-1:0] frz;
  logic [FILT_W-1:0] f1_prev;
  logic [7:0] pres_mag;
  logic [7:0] mot_mag;
  logic [7:0] shock_mag;
  logic [2:0] sign;
  logic mot_cond_q;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      obj <= '0;
      amb <= '0;
      f1 <= '0;
      f2 <= '0;
      af <= '0;
    end else if (SAMPLE_VALID) begin
      obj <= OBJECT_RAW_SAMPLE;
      amb <= AMBIENT_RAW_SAMPLE;
      f1 <= OBJECT_FILTER_ONE;
      f2 <= OBJECT_FILTER_TWO;
      af <= AMBIENT_FILTER_THREE;
    end
  end

  // Freeze on the rising edge of the motion condition
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      mot_cond_q <= 1'b0;
      frz <= '0;
    end else begin
      mot_cond_q <= MOTION_COND;
      if (MOTION_COND && !mot_cond_q) begin
        frz <= {f2, {FRZ_SHIFT{1'b0}}};
      end
    end
  end

  // ****************************************
  // Differences as sign and magnitude
  // ****************************************
  // Magnitude saturates at 255 rather than wrapping
  function automatic logic [8:0] sgn_mag(input logic signed [23:0] d);
    logic [23:0] m;
    m = d[23] ? 24'(-d) : 24'(d);
    return {d[23], (|m[23:8]) ? 8'hff : m[7:0]};
  endfunction

  logic signed [23:0] op_a;
  logic signed [23:0] op_b;
  logic signed [23:0] pres_d;
  logic signed [23:0] mot_d;
  logic signed [23:0] shock_d;
  logic [8:0] pres_sm;
  logic [8:0] mot_sm;
  logic [8:0] shock_sm;

  // Operands are compared on the filter scale, eight times raw
  always_comb begin
    op_a = 24'(f1);
    op_b = 24'(f2);
    unique case (tsr_src_t'(SRC_SELECT))
      TSR_SRC_OBJ_F2: begin
        op_a = 24'({obj, {FILT_SHIFT{1'b0}}});
        op_b = 24'(f2);
      end
      TSR_SRC_F1_F2: begin
        op_a = 24'(f1);
        op_b = 24'(f2);
      end
      TSR_SRC_OBJ_FRZ: begin
        op_a = 24'({obj, {FILT_SHIFT{1'b0}}});
        op_b = 24'(frz >> FRZ_SHIFT);
      end
      TSR_SRC_F1_FRZ: begin
        op_a = 24'(f1);
        op_b = 24'(frz >> FRZ_SHIFT);
      end
    endcase
  end

  assign pres_d = (op_a - op_b) >>> FILT_SHIFT;
  assign mot_d = (signed'(24'(f1)) - signed'(24'(f1_prev)))
                 >>> FILT_SHIFT;
  assign shock_d = 24'(amb) - 24'(af >> 1);
  assign pres_sm = sgn_mag(pres_d);
  assign mot_sm = sgn_mag(mot_d);
  assign shock_sm = sgn_mag(shock_d);

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      f1_prev <= '0;
    end else if (MOTION_TICK) begin
      f1_prev <= f1;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      pres_mag <= 8'h00;
      mot_mag <= 8'h00;
      shock_mag <= 8'h00;
      sign <= 3'h0;
    end else begin
      pres_mag <= pres_sm[7:0];
      mot_mag <= mot_sm[7:0];
      shock_mag <= shock_sm[7:0];
      sign <= {pres_sm[8], mot_sm[8], shock_sm[8]};
    end
  end

  // ****************************************
  // Timer half-period tracking
  // ****************************************
  logic timer_live;
  logic [1:0] halves;
  logic timer_evt;
  logic rd_clear;

  // Two half periods since the last read make one full period
  assign timer_evt = TIMER_HALF && (halves == TIMER_HALVES - 2'h1);

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      timer_live <= 1'b0;
    end else if (TIMER_HALF) begin
      timer_live <= ~timer_live;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      halves <= 2'h0;
    end else if (rd_clear) begin
      // A half period in the clearing cycle still counts
      halves <= (TIMER_HALF && !timer_evt) ? 2'h1 : 2'h0;
    end else if (TIMER_HALF && halves != TIMER_HALVES) begin
      halves <= halves + 2'h1;
    end
  end

  // ****************************************
  // Latched and live status
  // ****************************************
  logic [7:0] latched;
  logic [7:0] live;
  logic int_pend;

  assign live = {sign, OVER_TEMPERATURE_EVENT, PRESENCE_COND,
                 MOTION_COND, SHOCK_COND, timer_live};

  tsr_status i_tsr_status (
    .mclk(MCLK),
    .reset(RESET),
    .live_cond(live[BIT_OT:BIT_SHOCK]),
    .live_sign(sign),
    .timer_evt(timer_evt),
    .mask(INT_MASK),
    .rd_clear(rd_clear),
    .latched(latched),
    .int_pend(int_pend)
  );

  assign INT_N = ~int_pend;

  // ****************************************
  // Burst snapshot and read port
  // ****************************************
  // Results are copied once per burst so a multi-byte field
  // never mixes two sample updates
  logic [OBJ_W-1:0] s_obj;
  logic [AMB_W-1:0] s_amb;
  logic [FILT_W-1:0] s_f1;
  logic [FILT_W-1:0] s_f2;
  logic [AF_W-1:0] s_af;
  logic [FRZ_W-1:0] s_frz;
  logic [7:0] s_pres;
  logic [7:0] s_mot;
  logic [7:0] s_shock;
  logic in_burst;
  logic [5:0] ptr;
  logic [7:0] next_data;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      s_obj <= '0;
      s_amb <= '0;
      s_f1 <= '0;
      s_f2 <= '0;
      s_af <= '0;
      s_frz <= '0;
      s_pres <= 8'h00;
      s_mot <= 8'h00;
      s_shock <= 8'h00;
    end else if (RD_START || !in_burst) begin
      s_obj <= obj;
      s_amb <= amb;
      s_f1 <= f1;
      s_f2 <= f2;
      s_af <= af;
      s_frz <= frz;
      s_pres <= pres_mag;
      s_mot <= mot_mag;
      s_shock <= shock_mag;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      in_burst <= 1'b0;
    end else if (RD_START) begin
      in_burst <= 1'b1;
    end else if (RD_END) begin
      in_burst <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ptr <= 6'h00;
    end else if (RD_START) begin
      ptr <= RD_ADDR;
    end else if (RD_REQ) begin
      ptr <= (ptr == ADDR_LAST) ? 6'h00 : ptr + 6'h01;
    end
  end

  assign rd_clear = RD_REQ && !RD_START && ptr == OFS_LATCHED;

  always_comb begin
    next_data = READ_ZERO;
    case (ptr)
      OFS_OBJ_HIGH: next_data = s_obj[16:9];
      OFS_OBJ_MID: next_data = s_obj[8:1];
      OFS_OBJ_LOW_AMB_HIGH: next_data = {s_obj[0], s_amb[14:8]};
      OFS_AMB_LOW: next_data = s_amb[7:0];
      OFS_F1_HIGH: next_data = s_f1[19:12];
      OFS_F1_MID: next_data = s_f1[11:4];
      OFS_F1_LOW_F2_HIGH: next_data = {s_f1[3:0], s_f2[19:16]};
      OFS_F2_MID: next_data = s_f2[15:8];
      OFS_F2_LOW: next_data = s_f2[7:0];
      OFS_AF_HIGH: next_data = s_af[15:8];
      OFS_AF_LOW: next_data = s_af[7:0];
      OFS_FRZ_HIGH: next_data = s_frz[23:16];
      OFS_FRZ_MID: next_data = s_frz[15:8];
      OFS_FRZ_LOW: next_data = s_frz[7:0];
      OFS_PRESENCE: next_data = s_pres;
      OFS_MOTION: next_data = s_mot;
      OFS_SHOCK: next_data = s_shock;
      OFS_LATCHED: next_data = latched;
      OFS_LIVE: next_data = live;
      default: next_data = READ_ZERO;
    endcase
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      RD_DATA <= READ_ZERO;
      RD_ACK <= 1'b0;
    end else begin
      RD_ACK <= RD_REQ && !RD_START;
      if (RD_REQ && !RD_START) begin
        RD_DATA <= next_data;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_PTR_WRAP: assert property (
    @(posedge MCLK) disable iff (RESET)
    RD_REQ && !RD_START && ptr == ADDR_LAST |=> ptr == 6'h00)
    else $error("pointer did not wrap");
  AST_PTR_INC: assert property (
    @(posedge MCLK) disable iff (RESET)
    RD_REQ && !RD_START && ptr != ADDR_LAST |=> ptr == $past(ptr) + 6'h01)
    else $error("pointer did not increment");
  AST_SNAP_STABLE: assert property (
    @(posedge MCLK) disable iff (RESET)
    in_burst && !RD_START |=> $stable(s_f1) && $stable(s_obj))
    else $error("snapshot moved inside burst");
  AST_FREEZE: assert property (
    @(posedge MCLK) disable iff (RESET)
    MOTION_COND && !mot_cond_q |=> frz == {$past(f2), 4'h0})
    else $error("frozen copy not captured");
  AST_TIMER_TOGGLE: assert property (
    @(posedge MCLK) disable iff (RESET)
    TIMER_HALF |=> timer_live != $past(timer_live))
    else $error("timer bit did not toggle");
  AST_TIMER_FLAG: assert property (
    @(posedge MCLK) disable iff (RESET)
    timer_evt |=> latched[BIT_TIMER])
    else $error("timer flag not set");
  AST_LIVE_NOT_CLEARED: assert property (
    @(posedge MCLK) disable iff (RESET)
    RD_REQ && !RD_START && ptr == OFS_LIVE |=> RD_ACK ##0
    RD_DATA[4:1] == $past(live[4:1]))
    else $error("live status read wrong");
  AST_INT_PIN: assert property (
    @(posedge MCLK) disable iff (RESET)
    rd_clear && INT_MASK == 5'h00 |=> INT_N)
    else $error("read did not release pin");
  COV_BURST: cover property (
    @(posedge MCLK) disable iff (RESET) RD_START ##1 RD_REQ [*3]);
  COV_WRAP: cover property (
    @(posedge MCLK) disable iff (RESET) RD_REQ && ptr == ADDR_LAST);
  COV_FREEZE: cover property (
    @(posedge MCLK) disable iff (RESET) MOTION_COND && !mot_cond_q);
endmodule
`default_nettype wire

//--- tb/tsr_host.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Host side of the byte read port
// ****************************************
module tsr_host (
  // Clock
  input wire logic mclk,
  // Read port
  output logic rd_start = 1'b0,
  output logic [5:0] rd_addr = 6'h00,
  output logic rd_req = 1'b0,
  output logic rd_end = 1'b0,
  input wire logic [7:0] rd_data,
  input wire logic rd_ack
);
  task automatic start(input logic [5:0] a);
    rd_start = 1'b1;
    rd_addr = a;
    @(posedge mclk);
    #1 rd_start = 1'b0;
  endtask
  // Ack is due one edge after the request; later counts as a slip
  task automatic get(output logic [7:0] d, output bit ok);
    int n;
    rd_req = 1'b1;
    @(posedge mclk);
    #1 rd_req = 1'b0;
    n = 0;
    while (rd_ack !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1 n++;
    end
    d = rd_data;
    ok = (rd_ack === 1'b1) && (n == 0);
    // Idle edge so the next request is a fresh pulse
    @(posedge mclk);
    #1;
  endtask
  task automatic stop();
    rd_end = 1'b1;
    @(posedge mclk);
    #1 rd_end = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/tsr_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module tsr_regs_bench;
  import tsr_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic sv = 1'b0;
  logic [16:0] obj = 17'h00000;
  logic [14:0] amb = 15'h0105;
  logic [19:0] f1 = 20'h00000;
  logic [19:0] f2 = 20'h80100;
  logic [15:0] af = 16'h0200;
  logic [1:0] src = 2'h0;
  logic tick = 1'b0;
  logic half = 1'b0;
  logic [4:0] msk = 5'h00;
  logic ot = 1'b0;
  logic pres = 1'b0;
  logic mot = 1'b0;
  logic shk = 1'b0;
  logic rd_start, rd_req, rd_end, rd_ack, int_n;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] b [0:15];
  int err_count = 0;
  int comparisons = 0;

  always #5 mclk = ~mclk;

  tsr_regs i_tsr_regs (
    .MCLK(mclk), .RESET(reset), .SAMPLE_VALID(sv),
    .OBJECT_RAW_SAMPLE(obj), .AMBIENT_RAW_SAMPLE(amb),
    .OBJECT_FILTER_ONE(f1), .OBJECT_FILTER_TWO(f2),
    .AMBIENT_FILTER_THREE(af), .SRC_SELECT(src), .MOTION_TICK(tick),
    .TIMER_HALF(half), .INT_MASK(msk), .OVER_TEMPERATURE_EVENT(ot),
    .PRESENCE_COND(pres), .MOTION_COND(mot), .SHOCK_COND(shk),
    .RD_START(rd_start), .RD_ADDR(rd_addr), .RD_REQ(rd_req),
    .RD_END(rd_end), .RD_DATA(rd_data), .RD_ACK(rd_ack), .INT_N(int_n)
  );
  tsr_host i_tsr_host (
    .mclk(mclk), .rd_start(rd_start), .rd_addr(rd_addr),
    .rd_req(rd_req), .rd_end(rd_end), .rd_data(rd_data), .rd_ack(rd_ack)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task complete_run();
    $display("Counts: %0d compared, %0d failed", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task gt(output logic [7:0] d);
    bit ok;
    i_tsr_host.get(d, ok);
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED %0t no ack", $time);
      complete_run();
    end
  endtask
  task rd(input logic [5:0] a, input int n);
    i_tsr_host.start(a);
    for (int i = 0; i < n; i++) begin
      gt(b[i]);
    end
    i_tsr_host.stop();
  endtask
  task smp(input logic [16:0] o, input logic [19:0] f);
    obj = o;
    f1 = f;
    sv = 1'b1;
    cyc(1);
    sv = 1'b0;
    cyc(3);
  endtask
  function automatic logic [7:0] mag(input int d);
    int a;
    a = (d < 0) ? -d : d;
    return (a > 255) ? 8'hff : a[7:0];
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset();
    chk({7'h00, int_n}, 8'h01, "int idle");
    rd(6'h12, 3);
    chk(b[0], 8'h00, "latched rst");
    chk(b[1], 8'h00, "live rst");
    chk(b[2], 8'h00, "unmapped");
    $display("t_reset done");
  endtask
  task t_pack();
    logic [87:0] e;
    smp(17'h10021, 20'h80128);
    e = {obj, amb, f1, f2, af};
    rd(6'h01, 11);
    for (int i = 0; i < 11; i++) begin
      chk(b[i], e[87-8*i -: 8], "field");
    end
    $display("t_pack done");
  endtask
  task t_freeze();
    logic [23:0] e;
    mot = 1'b1;
    cyc(4);
    e = {f2, 4'h0};
    rd(6'h0c, 3);
    for (int i = 0; i < 3; i++) begin
      chk(b[i], e[23-8*i -: 8], "frozen");
    end
    rd(6'h12, 2);
    chk(b[0], 8'h04, "motion latched");
    chk(b[1], 8'h04, "motion live");
    chk({7'h00, int_n}, 8'h01, "masked off");
    rd(6'h12, 2);
    chk(b[0], 8'h00, "cleared");
    chk(b[1], 8'h04, "live kept");
    mot = 1'b0;
    $display("t_freeze done");
  endtask
  task t_src();
    int d;
    for (int s = 0; s < 4; s++) begin
      src = s[1:0];
      cyc(3);
      d = (s[0] ? int'(f1) : int'(obj) * 8)
        - (s[1] ? int'({f2, 4'h0}) / 16 : int'(f2));
      rd(6'h0f, 1);
      chk(b[0], mag(d >>> 3), "presence");
    end
    $display("t_src done");
  endtask
  task t_motion();
    int p;
    p = int'(f1);
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    smp(obj, 20'h800d8);
    rd(6'h0f, 3);
    chk(b[0], mag((int'(f1) - int'(f2)) >>> 3), "pres neg");
    chk(b[1], mag((int'(f1) - p) >>> 3), "motion");
    chk(b[2], mag(int'(amb) - int'(af) / 2), "shock");
    rd(6'h13, 1);
    chk(b[0] & 8'he0, 8'hc0, "signs");
    $display("t_motion done");
  endtask
  task t_int();
    int n;
    msk = 5'h08;
    pres = 1'b1;
    shk = 1'b1;
    ot = 1'b1;
    n = 0;
    while (int_n !== 1'b0 && n < 8) begin
      cyc(1);
      n++;
    end
    chk({7'h00, int_n}, 8'h00, "int low");
    cyc(6);
    chk({7'h00, int_n}, 8'h00, "int held");
    rd(6'h12, 1);
    chk(b[0], 8'h9a, "accumulated");
    cyc(2);
    chk({7'h00, int_n}, 8'h01, "int released");
    rd(6'h12, 1);
    chk(b[0], 8'h00, "cleared");
    pres = 1'b0;
    shk = 1'b0;
    ot = 1'b0;
    $display("t_int done");
  endtask
  task t_timer();
    msk = 5'h01;
    half = 1'b1;
    cyc(1);
    half = 1'b0;
    cyc(3);
    chk({7'h00, int_n}, 8'h01, "half only");
    rd(6'h13, 1);
    chk(b[0] & 8'h01, 8'h01, "live toggle");
    half = 1'b1;
    cyc(1);
    half = 1'b0;
    cyc(3);
    chk({7'h00, int_n}, 8'h00, "timer int");
    rd(6'h12, 1);
    chk(b[0], 8'h01, "timer flag");
    rd(6'h13, 1);
    chk(b[0] & 8'h01, 8'h00, "live back");
    $display("t_timer done");
  endtask
  task t_wrap();
    rd(6'h3f, 3);
    chk(b[0], 8'h00, "addr 63");
    chk(b[1], 8'h00, "addr 0");
    chk(b[2], obj[16:9], "addr 1");
    $display("t_wrap done");
  endtask
  task t_snap();
    logic [16:0] o;
    o = obj;
    i_tsr_host.start(6'h01);
    gt(b[0]);
    smp(17'h0ffff, f1);
    gt(b[1]);
    i_tsr_host.stop();
    chk(b[1], o[8:1], "burst stale");
    rd(6'h01, 2);
    chk(b[0], obj[16:9], "new high");
    chk(b[1], obj[8:1], "new mid");
    $display("t_snap done");
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    t_reset();
    t_pack();
    t_freeze();
    t_src();
    t_motion();
    t_int();
    t_timer();
    t_wrap();
    t_snap();
    complete_run();
  end
endmodule
`default_nettype wire
